// ### sdli_image.sv
// slave data image and slave list image of the network master
`include "sdli_consts.svh"
module sdli_image #(
  parameter int DATA_BYTES = `SDLI_DATA_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_wr_valid,
  input wire logic [5:0] in_wr_addr,
  input wire logic [3:0] in_wr_data,
  input wire logic [5:0] out_rd_addr,
  output logic [3:0] out_rd_data,
  input wire logic [63:0] detected_slave_list,
  input wire logic [63:0] activated_slave_list,
  output logic [63:0] projected_slave_list,
  input wire logic cfg_err_valid,
  input wire logic [5:0] cfg_err_addr,
  input wire logic power_fail,
  input wire logic pf_valid,
  input wire logic [5:0] pf_addr,
  input wire logic pf_state,
  input wire logic offline_by_list_en,
  input wire logic offline_release,
  output logic offline_enter,
  output logic config_error_report,
  output logic offline_phase,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [2:0] host_region,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (DATA_BYTES != `SDLI_DATA_BYTES) begin : g_bad_size
    $error("data image must be 32 bytes to hold 64 nibbles");
  end

  sdli_pkg::sdli_region_t region;
  logic [7:0] in_img [DATA_BYTES];
  logic [7:0] out_img [DATA_BYTES];
  logic [63:0] offline_trigger_slave_list;
  logic [63:0] peripheral_fault_list;
  logic [63:0] corrupted_slave_list;
  logic [63:0] proj_q;
  logic listed;
  logic trigger;
  logic list_ok;
  logic [7:0] rd_byte;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic enter_q;
  logic report_q;
  logic phase_q;
  logic [3:0] od_q;

  assign region = sdli_pkg::sdli_region_t'(host_region);
  assign list_ok = host_addr < 5'(`SDLI_LIST_BYTES);

  // ----------------------------------------
  // data image
  // ----------------------------------------
  function automatic logic [7:0] put_nib(input logic [7:0] b, input logic hi,
                                         input logic [3:0] n);
    logic [7:0] r;
    r = b;
    if (hi) begin
      r[7:4] = n;
    end else begin
      r[3:0] = n;
    end
    return r;
  endfunction

  function automatic logic [3:0] get_nib(input logic [7:0] b, input logic hi);
    return hi ? b[7:4] : b[3:0];
  endfunction

  // even slave low nibble, odd high, B slaves from byte 16
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DATA_BYTES; i++) begin
        in_img[i] <= `SDLI_BYTE_RESET;
      end
    end else if (in_wr_valid) begin
      in_img[sdli_pkg::sdli_data_byte(in_wr_addr)] <= put_nib(
        in_img[sdli_pkg::sdli_data_byte(in_wr_addr)], in_wr_addr[0], in_wr_data);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DATA_BYTES; i++) begin
        out_img[i] <= `SDLI_BYTE_RESET;
      end
    end else if (host_wr && region == sdli_pkg::REG_OUT_DATA) begin
      out_img[host_addr] <= host_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      od_q <= 4'h0;
    end else begin
      od_q <= get_nib(out_img[sdli_pkg::sdli_data_byte(out_rd_addr)], out_rd_addr[0]);
    end
  end
  assign out_rd_data = od_q;

  // ----------------------------------------
  // host-written lists and the peripheral fault list
  // ----------------------------------------
  // slot of 0B is forced to zero so it never triggers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      proj_q <= `SDLI_LIST_RESET;
      offline_trigger_slave_list <= `SDLI_LIST_RESET;
    end else if (host_wr && list_ok) begin
      if (region == sdli_pkg::REG_PROJECTED) begin
        proj_q[{host_addr[2:0], 3'h0} +: 8] <= host_wdata;
        proj_q[`SDLI_B_BASE] <= 1'b0;
      end
      if (region == sdli_pkg::REG_OFFLINE) begin
        offline_trigger_slave_list[{host_addr[2:0], 3'h0} +: 8] <= host_wdata;
        offline_trigger_slave_list[`SDLI_B_BASE] <= 1'b0;
      end
    end
  end
  assign projected_slave_list = proj_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      peripheral_fault_list <= `SDLI_LIST_RESET;
    end else if (pf_valid && sdli_pkg::sdli_valid(pf_addr)) begin
      peripheral_fault_list[pf_addr] <= pf_state;
    end
  end

  // ----------------------------------------
  // corrupted-slave list
  // ----------------------------------------
  sdli_corr_if corr ();
  assign corr.set_valid = cfg_err_valid;
  assign corr.set_addr = cfg_err_addr;
  assign corr.power_fail = power_fail;
  assign corr.clr_valid = host_rd && list_ok && region == sdli_pkg::REG_CORRUPTED;
  assign corr.clr_byte = host_addr[2:0];
  assign corrupted_slave_list = corr.list;

  sdli_corrupt_list u_corrupt (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .c(corr.owner)
  );

  // ----------------------------------------
  // reaction to configuration errors
  // ----------------------------------------
  assign listed = offline_trigger_slave_list[cfg_err_addr];
  // without list selection every error is critical
  assign trigger = cfg_err_valid && (!offline_by_list_en || listed);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      enter_q <= 1'b0;
      report_q <= 1'b0;
    end else begin
      enter_q <= trigger;
      report_q <= cfg_err_valid;
    end
  end

  // entry wins over a release in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
    end else if (trigger) begin
      phase_q <= 1'b1;
    end else if (offline_release) begin
      phase_q <= 1'b0;
    end
  end

  assign offline_enter = enter_q;
  assign config_error_report = report_q;
  assign offline_phase = phase_q;

  // ----------------------------------------
  // host read path
  // ----------------------------------------
  function automatic logic [7:0] list_byte(input logic [63:0] l, input logic [2:0] b);
    return l[{b, 3'h0} +: 8];
  endfunction

  always_comb begin
    rd_byte = 8'h00;
    case (region)
      sdli_pkg::REG_IN_DATA: rd_byte = in_img[host_addr];
      sdli_pkg::REG_OUT_DATA: rd_byte = out_img[host_addr];
      sdli_pkg::REG_PROJECTED: rd_byte = list_byte(proj_q, host_addr[2:0]);
      sdli_pkg::REG_DETECTED: rd_byte = list_byte(detected_slave_list, host_addr[2:0]);
      sdli_pkg::REG_ACTIVATED: rd_byte = list_byte(activated_slave_list, host_addr[2:0]);
      sdli_pkg::REG_CORRUPTED: rd_byte = list_byte(corrupted_slave_list, host_addr[2:0]);
      sdli_pkg::REG_OFFLINE: rd_byte = list_byte(offline_trigger_slave_list, host_addr[2:0]);
      sdli_pkg::REG_PERIPH: rd_byte = list_byte(peripheral_fault_list, host_addr[2:0]);
      default: rd_byte = 8'h00;
    endcase
    // lists are only 8 bytes long
    if (region != sdli_pkg::REG_IN_DATA && region != sdli_pkg::REG_OUT_DATA && !list_ok) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_rd;
      if (host_rd) begin
        rdata_q <= rd_byte;
      end
    end
  end
  assign host_rdata = rdata_q;
  assign host_rvalid = rvalid_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_listed_err;
    cfg_err_valid && offline_by_list_en && listed;
  endsequence
  sequence s_unlisted_err;
    cfg_err_valid && offline_by_list_en && !listed;
  endsequence

  a_listed_goes_offline: assert property (s_listed_err |=> offline_enter ##0 offline_phase)
    else $error("listed slave error did not enter off-line");
  a_unlisted_reports_only: assert property (
    (s_unlisted_err and !phase_q) |=> config_error_report && !offline_enter && !offline_phase)
    else $error("unlisted slave error left cycling");
  a_nibble_stored: assert property (
    in_wr_valid |=> get_nib(in_img[$past(in_wr_addr[5:1])], $past(in_wr_addr[0]))
      == $past(in_wr_data))
    else $error("input nibble not stored at its slot");
  a_slave0_low_nibble: assert property (
    in_wr_valid && in_wr_addr == 6'h00 |=> in_img[0][3:0] == $past(in_wr_data))
    else $error("slave 0 not in low nibble of byte 0");
  a_b_slave_upper: assert property (
    in_wr_valid && in_wr_addr == 6'h3F |=> in_img[31][7:4] == $past(in_wr_data))
    else $error("slave 31B not in high nibble of byte 31");
  a_list_read_map: assert property (
    host_rd && region == sdli_pkg::REG_DETECTED && list_ok
      |=> host_rvalid && host_rdata == $past(detected_slave_list[host_addr[2:0] * 8 +: 8]))
    else $error("list byte read from wrong bits");
  a_offline_list_write: assert property (
    host_wr && region == sdli_pkg::REG_OFFLINE && host_addr == 5'h00
      |=> offline_trigger_slave_list[7:0] == $past(host_wdata))
    else $error("off-line trigger list not written");
  a_periph_fault_set: assert property (
    pf_valid && sdli_pkg::sdli_valid(pf_addr)
      |=> peripheral_fault_list[$past(pf_addr)] == $past(pf_state))
    else $error("peripheral fault bit not updated");
endmodule // sdli_image

// ### sdli_consts.svh
// constants for the slave data and list image
`ifndef SDLI_CONSTS_SVH
`define SDLI_CONSTS_SVH
`define SDLI_DATA_BYTES 32
`define SDLI_LIST_BYTES 8
`define SDLI_SLAVES 64
`define SDLI_NIB_W 4
`define SDLI_B_BASE 32
`define SDLI_PWR_FAIL_BIT 0
`define SDLI_LIST_RESET 64'h0000000000000000
`define SDLI_BYTE_RESET 8'h00
`endif

// ### sdli_pkg.sv
// types and shared helpers for the slave data and list image
package sdli_pkg;
  // host access regions of the image
  typedef enum logic [2:0] {
    REG_IN_DATA,
    REG_OUT_DATA,
    REG_PROJECTED,
    REG_DETECTED,
    REG_ACTIVATED,
    REG_CORRUPTED,
    REG_OFFLINE,
    REG_PERIPH
  } sdli_region_t;

  typedef logic [5:0] sdli_addr_t;
  typedef logic [63:0] sdli_list_t;

  // slave 0B has no list slot
  function automatic logic sdli_valid(input sdli_addr_t a);
    return a != 6'h20;
  endfunction

  // data byte that holds a slave nibble
  function automatic logic [4:0] sdli_data_byte(input sdli_addr_t a);
    return a[5:1];
  endfunction

  // one-hot list bit of a slave
  function automatic sdli_list_t sdli_onehot(input sdli_addr_t a);
    sdli_list_t m;
    m = '0;
    if (sdli_valid(a)) begin
      m[a] = 1'b1;
    end
    return m;
  endfunction
endpackage

// ### sdli_corr_if.sv
// carrier between the image and the corrupted-slave list
interface sdli_corr_if;
  logic set_valid;
  logic [5:0] set_addr;
  logic power_fail;
  logic clr_valid;
  logic [2:0] clr_byte;
  logic [63:0] list;
  modport owner (input set_valid, set_addr, power_fail, clr_valid, clr_byte, output list);
  modport user (output set_valid, set_addr, power_fail, clr_valid, clr_byte, input list);
endinterface

// ### sdli_corrupt_list.sv
// corrupted-slave list with clear on host read
`include "sdli_consts.svh"
module sdli_corrupt_list (
  input wire logic sys_clk,
  input wire logic rst_b,
  sdli_corr_if.owner c
);
  logic [63:0] list_q;
  logic [63:0] list_d;
  logic [63:0] set_m;
  logic [63:0] clr_m;

  // ----------------------------------------
  // set and clear
  // ----------------------------------------
  always_comb begin
    set_m = '0;
    if (c.set_valid) begin
      set_m = sdli_pkg::sdli_onehot(c.set_addr);
    end
    if (c.power_fail) begin
      set_m[`SDLI_PWR_FAIL_BIT] = 1'b1;
    end
    clr_m = '0;
    if (c.clr_valid) begin
      clr_m[{c.clr_byte, 3'h0} +: 8] = 8'hFF;
    end
    // set wins so an error in the read cycle is kept
    list_d = (list_q & ~clr_m) | set_m;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      list_q <= `SDLI_LIST_RESET;
    end else begin
      list_q <= list_d;
    end
  end

  assign c.list = list_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_corrupt_set_kept: assert property (
    c.set_valid && sdli_pkg::sdli_valid(c.set_addr) |=> list_q[$past(c.set_addr)])
    else $error("corrupted bit not set");
  a_power_fail_slot: assert property (c.power_fail |=> list_q[0])
    else $error("power failure not recorded at slot 0");
  a_read_clears: assert property (
    c.clr_valid && !c.set_valid && !c.power_fail |=> list_q[$past(c.clr_byte) * 8 +: 8] == 8'h00)
    else $error("corrupted byte not cleared by read");
endmodule // sdli_corrupt_list

// ### sdli_host_model.sv
// host side model that reads and writes the image over its byte port
module sdli_host_model (
  input wire logic sys_clk,
  output logic host_rd,
  output logic host_wr,
  output logic [2:0] host_region,
  output logic [4:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_region = 3'h0;
    host_addr = 5'h00;
    host_wdata = 8'h00;
  end

  // ------------------------------------------------
  // byte write: seen at the next edge, no answer
  // ------------------------------------------------
  task automatic wr(input logic [2:0] rg, input logic [4:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    host_wr <= 1'b1;
    host_region <= rg;
    host_addr <= ad;
    host_wdata <= d;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    // released data inverted so a stale byte never looks right
    host_wdata <= ~d;
  endtask

  // ------------------------------------------------
  // byte read: answer stands one cycle after the take
  // ------------------------------------------------
  task automatic rd(input logic [2:0] rg, input logic [4:0] ad, output logic [7:0] d,
                    output logic v);
    @(posedge sys_clk);
    host_rd <= 1'b1;
    host_region <= rg;
    host_addr <= ad;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    // answer stands from this edge to the next
    #1;
    v = host_rvalid;
    d = host_rdata;
  endtask
endmodule // sdli_host_model

// ### sdli_image_tb_top.sv
// self-checking testbench of the slave data and list image
module sdli_image_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, rst_b, in_wr_valid, cfg_err_valid, power_fail, pf_valid, pf_state;
  logic offline_by_list_en, offline_release, offline_enter, config_error_report, offline_phase;
  logic host_rd, host_wr, host_rvalid;
  logic [5:0] in_wr_addr, out_rd_addr, cfg_err_addr, pf_addr;
  logic [3:0] in_wr_data, out_rd_data;
  logic [63:0] detected_slave_list, activated_slave_list, projected_slave_list;
  logic [2:0] host_region;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  sdli_image dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .in_wr_valid(in_wr_valid),
    .in_wr_addr(in_wr_addr), .in_wr_data(in_wr_data), .out_rd_addr(out_rd_addr),
    .out_rd_data(out_rd_data), .detected_slave_list(detected_slave_list),
    .activated_slave_list(activated_slave_list), .projected_slave_list(projected_slave_list),
    .cfg_err_valid(cfg_err_valid), .cfg_err_addr(cfg_err_addr), .power_fail(power_fail),
    .pf_valid(pf_valid), .pf_addr(pf_addr), .pf_state(pf_state),
    .offline_by_list_en(offline_by_list_en), .offline_release(offline_release),
    .offline_enter(offline_enter), .config_error_report(config_error_report),
    .offline_phase(offline_phase), .host_rd(host_rd), .host_wr(host_wr),
    .host_region(host_region), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  sdli_host_model host_u (.sys_clk(sys_clk), .host_rd(host_rd), .host_wr(host_wr),
    .host_region(host_region), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  // ------------------------------------------------
  // verdict, comparison and hang guard
  // ------------------------------------------------
  task automatic tally_and_finish();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // whole run needs about 140 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------
  // stimulus helpers
  // ------------------------------------------------
  task automatic hchk(input logic [2:0] rg, input logic [4:0] ad, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host_u.rd(rg, ad, d, v);
    chk(v, 1'b1);
    chk(d, e);
  endtask

  // kind 0 input nibble, 1 config error, 2 power loss, 3 peripheral fault
  task automatic net_ev(input int k, input logic [5:0] a, input logic [3:0] v);
    @(posedge sys_clk);
    in_wr_addr <= a;
    cfg_err_addr <= a;
    pf_addr <= a;
    in_wr_data <= v;
    pf_state <= v[0];
    in_wr_valid <= (k == 0);
    cfg_err_valid <= (k == 1);
    power_fail <= (k == 2);
    pf_valid <= (k == 3);
    @(posedge sys_clk);
    in_wr_valid <= 1'b0;
    cfg_err_valid <= 1'b0;
    power_fail <= 1'b0;
    pf_valid <= 1'b0;
    // pulses stand for one cycle only
    #1;
  endtask

  task automatic rel(input logic by_list);
    @(posedge sys_clk);
    offline_release <= 1'b1;
    offline_by_list_en <= by_list;
    @(posedge sys_clk);
    offline_release <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(offline_phase, 1'b0);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_in_data();
    net_ev(0, 6'h00, 4'hF);
    net_ev(0, 6'h01, 4'h3);
    net_ev(0, 6'h1F, 4'hA);
    net_ev(0, 6'h3E, 4'h5);
    net_ev(0, 6'h3F, 4'hC);
    hchk(sdli_pkg::REG_IN_DATA, 5'h00, 8'h3F);
    hchk(sdli_pkg::REG_IN_DATA, 5'h0F, 8'hA0);
    hchk(sdli_pkg::REG_IN_DATA, 5'h1F, 8'hC5);
    host_u.wr(sdli_pkg::REG_IN_DATA, 5'h00, 8'h00);
    hchk(sdli_pkg::REG_IN_DATA, 5'h00, 8'h3F);
  endtask

  task automatic t_out_data();
    logic [5:0] oa [4] = '{6'h1E, 6'h1F, 6'h20, 6'h21};
    logic [3:0] oe [4] = '{4'hE, 4'h9, 4'h1, 4'h7};
    host_u.wr(sdli_pkg::REG_OUT_DATA, 5'h0F, 8'h9E);
    host_u.wr(sdli_pkg::REG_OUT_DATA, 5'h10, 8'h71);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      out_rd_addr <= oa[i];
      repeat (2) @(posedge sys_clk);
      #1;
      chk(out_rd_data, oe[i]);
    end
  endtask

  task automatic t_lists();
    logic [63:0] dl;
    logic [63:0] al;
    dl = 64'h8421_0F1E_C3B4_5A69;
    al = 64'h1234_5678_9ABC_DEF0;
    @(posedge sys_clk);
    detected_slave_list <= dl;
    activated_slave_list <= al;
    for (int k = 0; k < 8; k++) begin
      hchk(sdli_pkg::REG_DETECTED, 5'(k), dl[8*k+:8]);
      hchk(sdli_pkg::REG_ACTIVATED, 5'(k), al[8*k+:8]);
    end
    hchk(sdli_pkg::REG_DETECTED, 5'h09, 8'h00);
    host_u.wr(sdli_pkg::REG_PROJECTED, 5'h04, 8'hFF);
    host_u.wr(sdli_pkg::REG_PROJECTED, 5'h00, 8'h81);
    @(posedge sys_clk);
    #1;
    chk(projected_slave_list, 64'h0000_00FE_0000_0081);
    hchk(sdli_pkg::REG_PROJECTED, 5'h04, 8'hFE);
  endtask

  task automatic t_corrupt();
    net_ev(1, 6'h05, 4'h0);
    net_ev(1, 6'h21, 4'h0);
    net_ev(1, 6'h20, 4'h0);
    net_ev(2, 6'h00, 4'h0);
    hchk(sdli_pkg::REG_CORRUPTED, 5'h00, 8'h21);
    hchk(sdli_pkg::REG_CORRUPTED, 5'h04, 8'h02);
    hchk(sdli_pkg::REG_CORRUPTED, 5'h00, 8'h00);
    hchk(sdli_pkg::REG_CORRUPTED, 5'h04, 8'h00);
  endtask

  task automatic t_offline();
    rel(1'b1);
    host_u.wr(sdli_pkg::REG_OFFLINE, 5'h00, 8'h20);
    hchk(sdli_pkg::REG_OFFLINE, 5'h00, 8'h20);
    host_u.wr(sdli_pkg::REG_OFFLINE, 5'h04, 8'hFF);
    hchk(sdli_pkg::REG_OFFLINE, 5'h04, 8'hFE);
    net_ev(1, 6'h06, 4'h0);
    chk(config_error_report, 1'b1);
    chk(offline_enter, 1'b0);
    chk(offline_phase, 1'b0);
    net_ev(1, 6'h05, 4'h0);
    chk({offline_enter, config_error_report, offline_phase}, 3'h7);
    @(posedge sys_clk);
    #1;
    chk({offline_enter, offline_phase}, 2'h1);
    rel(1'b0);
    net_ev(1, 6'h06, 4'h0);
    chk(offline_enter, 1'b1);
    rel(1'b0);
  endtask

  task automatic t_periph();
    net_ev(3, 6'h03, 4'h1);
    net_ev(3, 6'h28, 4'h1);
    hchk(sdli_pkg::REG_PERIPH, 5'h00, 8'h08);
    hchk(sdli_pkg::REG_PERIPH, 5'h05, 8'h01);
    net_ev(3, 6'h03, 4'h0);
    hchk(sdli_pkg::REG_PERIPH, 5'h00, 8'h00);
  endtask

  initial begin
    rst_b = 1'b0;
    {in_wr_valid, cfg_err_valid, power_fail, pf_valid, pf_state} = 5'h00;
    {offline_by_list_en, offline_release} = 2'h0;
    {in_wr_addr, out_rd_addr, cfg_err_addr, pf_addr} = 24'h000000;
    in_wr_data = 4'h0;
    detected_slave_list = 64'h0;
    activated_slave_list = 64'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk(projected_slave_list, 64'h0);
    chk({offline_phase, offline_enter}, 2'h0);
    hchk(sdli_pkg::REG_CORRUPTED, 5'h00, 8'h00);
    t_in_data();
    t_out_data();
    t_lists();
    t_corrupt();
    t_offline();
    t_periph();
    tally_and_finish();
  end
endmodule // sdli_image_tb_top
